// File: external_bus_pkg.sv
`default_nettype none
package external_bus_pkg;
  // Bus geometry.
  localparam int ADDR_W  = 24;
  localparam int DATA_W  = 16;
  localparam int NUM_WIN = 4;
  localparam int NUM_CS  = 5;
  localparam int SEG_LSB = 16;

  // Address lines reach the full 24-bit space at most.
  localparam logic [4:0] MAX_ADDR_LINES = 5'h18;

  // Internal peripheral bus ranges; the reserved holes around them go external.
  localparam logic [23:0] PERIPH_LO_START = 24'h200000;
  localparam logic [23:0] PERIPH_LO_END   = 24'h205FFF;
  localparam logic [23:0] PERIPH_HI_START = 24'h208000;
  localparam logic [23:0] PERIPH_HI_END   = 24'h20BBFF;

  // Reset values.
  localparam logic [4:0]  CS_N_RESET  = 5'h1F;
  localparam logic [15:0] DATA_RESET  = 16'h0000;
  localparam logic [23:0] ADDR_RESET  = 24'h000000;
  localparam logic [3:0]  CNT_RESET   = 4'h0;

  // Window select: a window covers (4 Kbytes << size) starting at base * 4 Kbytes.
  typedef struct packed {
    logic        enable;
    logic [11:0] base;
    logic [3:0]  size;
  } window_sel_t;

  // Per chip-select timing: address phase, command wait states and hold, in reference clock out cycles of two link cycles each.
  typedef struct packed {
    logic [1:0] addr_cycles;
    logic [3:0] wait_states;
    logic [1:0] hold_cycles;
  } timing_cfg_t;

  // Per chip-select function: chip select on, demultiplexed, 16-bit, ready used, ready polarity.
  typedef struct packed {
    logic cs_enable;
    logic demux;
    logic bus16;
    logic ready_en;
    logic ready_high;
  } function_cfg_t;

  // Internal peripheral accesses run demultiplexed, 16-bit, without ready.
  localparam function_cfg_t INTERNAL_FCFG = 5'h0C;

  // Request from the system bus.
  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] wdata;
    logic        write;
    logic        word;
  } access_req_t;

  // Access handed to the link side.
  typedef struct packed {
    logic [23:0]   addr;
    logic [15:0]   wdata;
    logic          write;
    logic          word;
    logic          internal;
    logic [2:0]    region;
    logic [4:0]    addr_lines;
    timing_cfg_t   tcfg;
    function_cfg_t fcfg;
  } bus_cmd_t;

  // Answer to the system bus.
  typedef struct packed {
    logic [15:0] rdata;
    logic        err;
  } access_resp_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_ADDR = 4'h2,
    S_CMD  = 4'h4,
    S_HOLD = 4'h8
  } bus_state_t;
endpackage : external_bus_pkg
`default_nettype wire

// File: external_bus_ctrl.sv
// Functional notes
// - Single-chip mode refuses external accesses; external mode runs them on the bus.
// - Driven address lines are programmable from zero to twenty-four.
// - Data bus width is 8 or 16 bits per region.
// - Multiplexed and demultiplexed bus operation are both supported.
// - Address and data share lines in multiplexed mode; demultiplexed mode drives low address lines instead.
// - Segment address line count selectable; unused lines are released.
// - One active-low chip select per window plus one for default region.
// - Timing and function settings are programmable per chip-select region.
// - Ready input extends accesses; its active polarity is configurable.
// - Four independent address windows each select their own bus characteristics.
// - Window 4 beats 3, 2 beats 1 on overlap.
// - Accesses hitting no window use default region settings.
// - Only the decoded window may assert its chip select.
// - Bus signal changes are aligned to rising edge of reference clock out.
// - Bus mode switches access by access according to decoded window.
// - On-chip peripheral accesses run on the internal peripheral bus.
// - Reserved address areas become external bus accesses.
// - Address space is 256 segments of 64 Kbytes on segment lines.
// - Byte and word accesses are allowed anywhere.
// - Reference clock output is the link clock divided by two, from a dedicated toggle flop.
`timescale 1ns/1ns
`default_nettype none
module external_bus_ctrl
  import external_bus_pkg::*;
(
  // System side clock and reset.
  input  wire logic                  ref_clk,
  input  wire logic                  resetn,
  // Bus link clock.
  input  wire logic                  link_clk,
  // Configuration.
  input  wire logic                  ext_mode_en,
  input  wire logic [4:0]            addr_lines_cfg,
  input  wire window_sel_t [3:0]     window_address_select,
  input  wire timing_cfg_t [3:0]     cs_timing_cfg,
  input  wire function_cfg_t [3:0]   cs_function_cfg,
  input  wire timing_cfg_t           default_timing_cfg,
  input  wire function_cfg_t         default_function_cfg,
  // Access request and answer.
  input  wire logic                  req_valid,
  input  wire access_req_t           req_data,
  output logic                       req_ready,
  output logic                       resp_valid,
  output access_resp_t               resp_data,
  // External bus pins.
  output logic                       bus_reference_clock_out,
  output logic [23:0]                addr_out,
  output logic [23:0]                addr_oe,
  output logic [15:0]                ad_out,
  output logic [1:0]                 ad_oe,
  input  wire logic [15:0]           ad_in,
  output logic                       ale,
  output logic                       rd_n,
  output logic                       wr_n,
  output logic                       bhe_n,
  output logic [4:0]                 cs_n,
  input  wire logic                  ready_pin,
  // Internal peripheral bus.
  output logic                       ipb_sel,
  output logic                       ipb_rd,
  output logic                       ipb_wr,
  output logic [23:0]                ipb_addr,
  output logic [15:0]                ipb_wdata,
  input  wire logic [15:0]           ipb_rdata
);

  // System side state.
  logic          req_ready_ff;
  logic          busy_ff;
  logic          resp_valid_ff;
  access_resp_t  resp_ff;
  bus_cmd_t      cmd_ff;
  bus_cmd_t      nxt_cmd;
  logic          req_tgl_ff;
  logic          ack_meta_ff;
  logic          ack_sync_ff;
  logic          ack_seen_ff;
  logic          take;
  logic          ack_edge;
  logic          req_internal;
  logic [3:0]    win_hit;
  logic [2:0]    region;

  // Link side state.
  logic          link_rst_meta_ff;
  logic          link_rst_n_ff;
  logic          req_meta_ff;
  logic          req_sync_ff;
  logic          req_taken_ff;
  logic          ack_tgl_ff;
  logic [15:0]   rdata_ff;
  logic [15:0]   ad_meta_ff;
  logic [15:0]   ad_sync_ff;
  logic          ready_meta_ff;
  logic          ready_sync_ff;
  logic          bus_reference_clock_out_ff;
  bus_state_t    state_ff;
  bus_state_t    nxt_state;
  logic [3:0]    cnt_ff;
  logic [3:0]    nxt_cnt;
  logic          second_ff;
  logic          nxt_second;
  logic          step;
  logic          pending;
  logic          ready_ok;
  logic          two_beats;
  logic          cmd_end;
  logic [23:0]   beat_addr;
  logic [23:0]   line_en;

  // Pin registers.
  logic [23:0]   addr_out_ff;
  logic [23:0]   addr_oe_ff;
  logic [15:0]   ad_out_ff;
  logic [1:0]    ad_oe_ff;
  logic          ale_ff;
  logic          rd_n_ff;
  logic          wr_n_ff;
  logic          bhe_n_ff;
  logic [4:0]    cs_n_ff;
  logic          ipb_sel_ff;
  logic          ipb_rd_ff;
  logic          ipb_wr_ff;
  logic [23:0]   ipb_addr_ff;
  logic [15:0]   ipb_wdata_ff;

  // ---------------------------------------------------------------- system side

  for (genvar gi = 0; gi < NUM_WIN; gi++) begin : g_win
    logic [11:0] mask;
    assign mask        = 12'hFFF << window_address_select[gi].size;
    assign win_hit[gi] = window_address_select[gi].enable &&
                         ((req_data.addr[23:12] & mask) == (window_address_select[gi].base & mask));
  end

  // reserved holes fall outside both ranges and so go external.
  assign req_internal = (req_data.addr >= PERIPH_LO_START && req_data.addr <= PERIPH_LO_END) ||
                        (req_data.addr >= PERIPH_HI_START && req_data.addr <= PERIPH_HI_END);

  // Later tests win, so window 4 has the highest priority.
  always_comb begin
    region = 3'h0;
    for (int i = 0; i < NUM_WIN; i++) begin
      if (win_hit[i]) begin
        region = 3'(i + 1);
      end
    end
  end

  // The snapshot carries the region's settings so a config change never tears a running access.
  always_comb begin
    nxt_cmd            = '0;
    nxt_cmd.addr       = req_data.word ? {req_data.addr[23:1], 1'b0} : req_data.addr;
    nxt_cmd.wdata      = req_data.wdata;
    nxt_cmd.write      = req_data.write;
    nxt_cmd.word       = req_data.word;
    nxt_cmd.internal   = req_internal;
    nxt_cmd.region     = region;
    nxt_cmd.addr_lines = (addr_lines_cfg > MAX_ADDR_LINES) ? MAX_ADDR_LINES : addr_lines_cfg;
    if (req_internal) begin
      nxt_cmd.tcfg = '0;
      nxt_cmd.fcfg = INTERNAL_FCFG;
    end else if (region == 3'h0) begin
      nxt_cmd.tcfg = default_timing_cfg;
      nxt_cmd.fcfg = default_function_cfg;
    end else begin
      nxt_cmd.tcfg = cs_timing_cfg[region - 3'h1];
      nxt_cmd.fcfg = cs_function_cfg[region - 3'h1];
    end
  end

  assign take     = req_valid && req_ready_ff;
  assign ack_edge = ack_sync_ff != ack_seen_ff;

  // Request handshake toward the link; cmd_ff holds still until the answer returns.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      req_ready_ff <= 1'b1;
      busy_ff      <= 1'b0;
      cmd_ff       <= '0;
      req_tgl_ff   <= 1'b0;
    end else begin
      req_ready_ff <= !take && !(busy_ff && !ack_edge);
      if (take && (req_internal || ext_mode_en)) begin
        cmd_ff     <= nxt_cmd;
        req_tgl_ff <= ~req_tgl_ff;
        busy_ff    <= 1'b1;
      end else if (ack_edge) begin
        busy_ff <= 1'b0;
      end
    end
  end

  // Answer toward the system bus.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      resp_valid_ff <= 1'b0;
      resp_ff       <= '0;
    end else begin
      resp_valid_ff <= 1'b0;
      if (take && !req_internal && !ext_mode_en) begin
        resp_valid_ff <= 1'b1;
        resp_ff       <= '{rdata: DATA_RESET, err: 1'b1};
      end else if (busy_ff && ack_edge) begin
        resp_valid_ff <= 1'b1;
        resp_ff       <= '{rdata: rdata_ff, err: 1'b0};
      end
    end
  end

  // Completion toggle crosses back through two flops.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ack_meta_ff <= 1'b0;
      ack_sync_ff <= 1'b0;
      ack_seen_ff <= 1'b0;
    end else begin
      ack_meta_ff <= ack_tgl_ff;
      ack_sync_ff <= ack_meta_ff;
      ack_seen_ff <= ack_sync_ff;
    end
  end

  // ---------------------------------------------------------------- link side

  // Reset release is resynchronised; these flops carry no reset themselves.
  always_ff @(posedge link_clk) begin
    link_rst_meta_ff <= resetn;
    link_rst_n_ff    <= link_rst_meta_ff;
  end

  // Pin and toggle synchronisers.
  always_ff @(posedge link_clk) begin
    if (!link_rst_n_ff) begin
      req_meta_ff   <= 1'b0;
      req_sync_ff   <= 1'b0;
      ad_meta_ff    <= DATA_RESET;
      ad_sync_ff    <= DATA_RESET;
      ready_meta_ff <= 1'b0;
      ready_sync_ff <= 1'b0;
    end else begin
      req_meta_ff   <= req_tgl_ff;
      req_sync_ff   <= req_meta_ff;
      ad_meta_ff    <= ad_in;
      ad_sync_ff    <= ad_meta_ff;
      ready_meta_ff <= ready_pin;
      ready_sync_ff <= ready_meta_ff;
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_n_ff) begin
      bus_reference_clock_out_ff <= 1'b0;
    end else begin
      bus_reference_clock_out_ff <= ~bus_reference_clock_out_ff;
    end
  end

  // steps only where clock out rises
  assign step      = !bus_reference_clock_out_ff;
  assign pending   = req_sync_ff != req_taken_ff;
  assign ready_ok  = !cmd_ff.fcfg.ready_en || (ready_sync_ff == cmd_ff.fcfg.ready_high);
  assign two_beats = cmd_ff.word && !cmd_ff.fcfg.bus16 && !cmd_ff.internal;
  assign cmd_end   = step && state_ff == S_CMD && cnt_ff == CNT_RESET && ready_ok;
  assign beat_addr = {cmd_ff.addr[23:1], cmd_ff.addr[0] | nxt_second};

  // segment lines above the count stay released
  for (genvar gl = 0; gl < ADDR_W; gl++) begin : g_line
    assign line_en[gl] = (5'(gl) < cmd_ff.addr_lines) && (cmd_ff.fcfg.demux || gl >= SEG_LSB);
  end

  // Access sequencer: address phase, command phase with waits and ready, hold.
  always_comb begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_second = second_ff;
    if (step) begin
      unique case (state_ff)
        S_IDLE: begin
          if (pending) begin
            nxt_state  = S_ADDR;
            nxt_cnt    = {2'h0, cmd_ff.tcfg.addr_cycles};
            nxt_second = 1'b0;
          end
        end
        S_ADDR: begin
          if (cnt_ff == CNT_RESET) begin
            nxt_state = S_CMD;
            nxt_cnt   = cmd_ff.tcfg.wait_states;
          end else begin
            nxt_cnt = cnt_ff - 4'h1;
          end
        end
        S_CMD: begin
          if (cnt_ff != CNT_RESET) begin
            nxt_cnt = cnt_ff - 4'h1;
          end else if (ready_ok) begin
            nxt_state = S_HOLD;
            nxt_cnt   = {2'h0, cmd_ff.tcfg.hold_cycles};
          end
        end
        S_HOLD: begin
          if (cnt_ff != CNT_RESET) begin
            nxt_cnt = cnt_ff - 4'h1;
          end else if (two_beats && !second_ff) begin
            nxt_state  = S_ADDR;
            nxt_cnt    = {2'h0, cmd_ff.tcfg.addr_cycles};
            nxt_second = 1'b1;
          end else begin
            nxt_state = S_IDLE;
          end
        end
      endcase
    end
  end

  // Sequencer state and completion toggle.
  always_ff @(posedge link_clk) begin
    if (!link_rst_n_ff) begin
      state_ff     <= S_IDLE;
      cnt_ff       <= CNT_RESET;
      second_ff    <= 1'b0;
      req_taken_ff <= 1'b0;
      ack_tgl_ff   <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      second_ff <= nxt_second;
      if (state_ff == S_IDLE && nxt_state == S_ADDR) begin
        req_taken_ff <= req_sync_ff;
      end
      if (state_ff == S_HOLD && nxt_state == S_IDLE) begin
        ack_tgl_ff <= ~ack_tgl_ff;
      end
    end
  end

  // Read data capture at the end of the command phase, placed by lane.
  always_ff @(posedge link_clk) begin
    if (!link_rst_n_ff) begin
      rdata_ff <= DATA_RESET;
    end else if (cmd_end && !cmd_ff.write) begin
      if (cmd_ff.internal) begin
        rdata_ff <= ipb_rdata;
      end else if (two_beats) begin
        if (second_ff) begin
          rdata_ff[15:8] <= ad_sync_ff[7:0];
        end else begin
          rdata_ff[7:0] <= ad_sync_ff[7:0];
        end
      end else if (cmd_ff.word) begin
        rdata_ff <= ad_sync_ff;
      end else if (cmd_ff.fcfg.bus16 && cmd_ff.addr[0]) begin
        rdata_ff <= {8'h00, ad_sync_ff[15:8]};
      end else begin
        rdata_ff <= {8'h00, ad_sync_ff[7:0]};
      end
    end
  end

  // External pins follow the next state, so every change lands on a rising clock out.
  always_ff @(posedge link_clk) begin
    if (!link_rst_n_ff) begin
      addr_out_ff <= ADDR_RESET;
      addr_oe_ff  <= ADDR_RESET;
      ad_out_ff   <= DATA_RESET;
      ad_oe_ff    <= 2'h0;
      ale_ff      <= 1'b0;
      rd_n_ff     <= 1'b1;
      wr_n_ff     <= 1'b1;
      bhe_n_ff    <= 1'b1;
      cs_n_ff     <= CS_N_RESET;
    end else begin
      addr_out_ff <= ADDR_RESET;
      addr_oe_ff  <= ADDR_RESET;
      ad_out_ff   <= DATA_RESET;
      ad_oe_ff    <= 2'h0;
      ale_ff      <= 1'b0;
      rd_n_ff     <= 1'b1;
      wr_n_ff     <= 1'b1;
      bhe_n_ff    <= 1'b1;
      cs_n_ff     <= CS_N_RESET;
      if (nxt_state != S_IDLE && !cmd_ff.internal) begin
        // segment lines carry address bits 23..16
        addr_out_ff <= beat_addr & line_en;
        addr_oe_ff  <= line_en;
        bhe_n_ff    <= !(cmd_ff.fcfg.bus16 && (cmd_ff.word || cmd_ff.addr[0]));
        if (cmd_ff.fcfg.cs_enable) begin
          cs_n_ff[cmd_ff.region] <= 1'b0;
        end
        if (nxt_state == S_ADDR && !cmd_ff.fcfg.demux) begin
          ale_ff    <= 1'b1;
          ad_out_ff <= beat_addr[15:0];
          ad_oe_ff  <= 2'h3;
        end
        if (nxt_state != S_ADDR && cmd_ff.write) begin
          ad_oe_ff <= cmd_ff.fcfg.bus16 ? 2'h3 : 2'h1;
          if (cmd_ff.fcfg.bus16) begin
            ad_out_ff <= cmd_ff.word ? cmd_ff.wdata : {cmd_ff.wdata[7:0], cmd_ff.wdata[7:0]};
          end else begin
            ad_out_ff <= {8'h00, nxt_second ? cmd_ff.wdata[15:8] : cmd_ff.wdata[7:0]};
          end
        end
        rd_n_ff <= !(nxt_state == S_CMD && !cmd_ff.write);
        wr_n_ff <= !(nxt_state == S_CMD && cmd_ff.write);
      end
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_n_ff) begin
      ipb_sel_ff   <= 1'b0;
      ipb_rd_ff    <= 1'b0;
      ipb_wr_ff    <= 1'b0;
      ipb_addr_ff  <= ADDR_RESET;
      ipb_wdata_ff <= DATA_RESET;
    end else begin
      ipb_sel_ff   <= nxt_state != S_IDLE && cmd_ff.internal;
      ipb_rd_ff    <= nxt_state == S_CMD && cmd_ff.internal && !cmd_ff.write;
      ipb_wr_ff    <= nxt_state == S_CMD && cmd_ff.internal && cmd_ff.write;
      ipb_addr_ff  <= cmd_ff.internal ? cmd_ff.addr : ADDR_RESET;
      ipb_wdata_ff <= cmd_ff.internal ? cmd_ff.wdata : DATA_RESET;
    end
  end

  // Outputs straight from flops.
  assign req_ready               = req_ready_ff;
  assign resp_valid              = resp_valid_ff;
  assign resp_data               = resp_ff;
  assign bus_reference_clock_out = bus_reference_clock_out_ff;
  assign addr_out                = addr_out_ff;
  assign addr_oe                 = addr_oe_ff;
  assign ad_out                  = ad_out_ff;
  assign ad_oe                   = ad_oe_ff;
  assign ale                     = ale_ff;
  assign rd_n                    = rd_n_ff;
  assign wr_n                    = wr_n_ff;
  assign bhe_n                   = bhe_n_ff;
  assign cs_n                    = cs_n_ff;
  assign ipb_sel                 = ipb_sel_ff;
  assign ipb_rd                  = ipb_rd_ff;
  assign ipb_wr                  = ipb_wr_ff;
  assign ipb_addr                = ipb_addr_ff;
  assign ipb_wdata               = ipb_wdata_ff;

  // ---------------------------------------------------------------- checks

  sequence s_take_ext_refused;
    take && !req_internal && !ext_mode_en;
  endsequence
  sequence s_error_answer;
    resp_valid_ff && resp_ff.err;
  endsequence
  property p_single_chip;
    @(posedge ref_clk) disable iff (!resetn) s_take_ext_refused |=> s_error_answer ##1 req_ready_ff;
  endproperty
  a_single_chip: assert property (p_single_chip) else $error("Refused access not answered with error.");
  property p_win_priority;
    @(posedge ref_clk) disable iff (!resetn)
      take && ext_mode_en && !req_internal && win_hit[3] |=> cmd_ff.region == 3'h4;
  endproperty
  a_win_priority: assert property (p_win_priority) else $error("Window 4 did not win decode.");
  property p_default_region;
    @(posedge ref_clk) disable iff (!resetn)
      take && ext_mode_en && !req_internal && win_hit == 4'h0 |=> cmd_ff.region == 3'h0;
  endproperty
  a_default_region: assert property (p_default_region) else $error("Unmatched access left default region.");
  // Link checks also sleep while the system reset is low, before the resynchronised copy has settled.
  property p_cs_single;
    @(posedge link_clk) disable iff (!resetn || !link_rst_n_ff) $onehot0(~cs_n_ff);
  endproperty
  a_cs_single: assert property (p_cs_single) else $error("More than one chip select active.");
  property p_cs_idle;
    @(posedge link_clk) disable iff (!resetn || !link_rst_n_ff) state_ff == S_IDLE |-> cs_n_ff == CS_N_RESET;
  endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("Chip select active between accesses.");
  property p_clk_align;
    @(posedge link_clk) disable iff (!resetn || !link_rst_n_ff) $changed(state_ff) |-> bus_reference_clock_out_ff;
  endproperty
  a_clk_align: assert property (p_clk_align) else $error("Bus step off the rising reference edge.");
  property p_bus_reference_clock_out_runs;
    @(posedge link_clk) disable iff (!resetn || !link_rst_n_ff) bus_reference_clock_out_ff |=> !bus_reference_clock_out_ff ##1 bus_reference_clock_out_ff;
  endproperty
  a_bus_reference_clock_out_runs: assert property (p_bus_reference_clock_out_runs) else $error("Reference clock output stalled.");
  property p_ready_hold;
    @(posedge link_clk) disable iff (!resetn || !link_rst_n_ff)
      step && state_ff == S_CMD && cnt_ff == CNT_RESET && !ready_ok |=>
        state_ff == S_CMD && (!rd_n_ff || !wr_n_ff);
  endproperty
  a_ready_hold: assert property (p_ready_hold) else $error("Access ended without ready.");
  property p_ale_mux;
    @(posedge link_clk) disable iff (!resetn || !link_rst_n_ff) ale_ff |-> !cmd_ff.fcfg.demux && rd_n_ff && wr_n_ff;
  endproperty
  a_ale_mux: assert property (p_ale_mux) else $error("Address latch pulse outside multiplexed phase.");
endmodule : external_bus_ctrl
`default_nettype wire

// File: ext_bus_partner.sv
`timescale 1ns/1ns
`default_nettype none
// Memory on the shared lines: a fixed read word and a ready of chosen delay and level.
module ext_bus_partner (
  // Bus pins.
  input  wire logic        link_clk,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  output logic [15:0]      ad_in,
  output logic             ready_pin,
  // Behaviour.
  input  wire logic        slow,
  input  wire logic        act_high
);
  logic [3:0] wait_ff;
  logic       strobe;

  // Reads and writes alike are stretched, so a write to a ready region cannot hang.
  assign strobe = !rd_n || !wr_n;

  always_ff @(posedge link_clk) begin
    wait_ff <= !strobe ? 4'h0 : wait_ff + ((wait_ff == 4'hF) ? 4'h0 : 4'h1);
  end

  // Released lines show the inverse word, so stale data can never match.
  assign ad_in = rd_n ? 16'h5AA5 : 16'hA55A;

  assign ready_pin = (strobe && wait_ff >= (slow ? 4'h6 : 4'h0)) ? act_high : !act_high;
endmodule : ext_bus_partner
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import external_bus_pkg::*;
  logic ref_clk = 0, link_clk = 0, resetn = 0, ext_mode_en = 1, req_valid = 0, slow = 0, act_high = 1;
  access_req_t req_data = '0;
  access_resp_t resp_data;
  logic req_ready, resp_valid, rd_n, wr_n, ready_pin;
  logic [15:0] ad_in, ad_out, wd_acc;
  logic [23:0] addr_out, ad_acc;
  logic [4:0] cs_n, cs_acc;
  int n_mismatch = 0, n_compared = 0, cyc = 0;

  // Both clocks run free; the link clock starts out of phase.
  initial forever #20 ref_clk = ~ref_clk;
  initial begin
    #3;
    forever #6 link_clk = ~link_clk;
  end

  external_bus_ctrl dut (.ref_clk(ref_clk), .resetn(resetn), .link_clk(link_clk), .ext_mode_en(ext_mode_en),
    .addr_lines_cfg(5'h18), .window_address_select({17'h14010, 17'h00000, 17'h14004, 17'h14008}),
    .cs_timing_cfg({4{8'h08}}), .cs_function_cfg({5'h1C, 5'h00, 5'h18, 5'h16}),
    .default_timing_cfg(8'h08), .default_function_cfg(5'h17), .req_valid(req_valid), .req_data(req_data),
    .req_ready(req_ready), .resp_valid(resp_valid), .resp_data(resp_data), .bus_reference_clock_out(),
    .addr_out(addr_out), .addr_oe(), .ad_out(ad_out), .ad_oe(), .ad_in(ad_in), .ale(), .rd_n(rd_n),
    .wr_n(wr_n), .bhe_n(),
    .cs_n(cs_n), .ready_pin(ready_pin), .ipb_sel(), .ipb_rd(), .ipb_wr(), .ipb_addr(), .ipb_wdata(),
    .ipb_rdata(16'h1234));

  ext_bus_partner mem (.link_clk(link_clk), .rd_n(rd_n), .wr_n(wr_n), .ad_in(ad_in), .ready_pin(ready_pin),
    .slow(slow), .act_high(act_high));

  // Gather the chip selects seen low, and the last address and write data seen under a strobe.
  always @(posedge link_clk) begin
    cs_acc = cs_acc | ~cs_n;
    if (!rd_n || !wr_n) ad_acc = addr_out;
    if (!wr_n) wd_acc = ad_out;
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  // One word access; the answer pulse is looked at 1 ns after each edge, while it stands.
  task automatic acc(input logic [23:0] a, input logic w, input logic [4:0] cs, input logic e,
                     input logic [15:0] d, input logic [23:0] ea);
    int n;
    n = 1;
    cs_acc = 5'h00;
    ad_acc = 24'h000000;
    wd_acc = 16'h0000;
    req_data = {a, 16'h3C5A, w, 1'b1};
    req_valid = 1;
    while (req_ready !== 1'b1) begin
      @(posedge ref_clk);
      #1;
    end
    @(posedge ref_clk);
    #1 req_valid = 0;
    while (resp_valid !== 1'b1 && n < 400) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk(resp_data.err, e);
    if (e) chk(n, 1);
    if (!w) chk(resp_data.rdata, d);
    if (w) chk(wd_acc, 16'h3C5A);
    chk(ad_acc, ea);
    chk(cs_acc, cs);
    chk(cs_n, 5'h1F);
  endtask : acc

  task automatic t_reset();
    chk(cs_n, 5'h1F);
    chk(resp_valid, 1'b0);
  endtask : t_reset

  task automatic t_refuse();
    ext_mode_en = 0;
    acc(24'h400000, 0, 5'h00, 1, 16'h0000, 24'h000000);
    ext_mode_en = 1;
  endtask : t_refuse

  // Window 2 is 8-bit demultiplexed: a word takes two byte beats, the last at the odd address.
  task automatic t_windows();
    acc(24'h400010, 0, 5'h04, 0, 16'h5A5A, 24'h400011);
    acc(24'h401000, 0, 5'h10, 0, 16'hA55A, 24'h401000);
    act_high = 0;
    acc(24'h480000, 0, 5'h02, 0, 16'hA55A, 24'h480000);
    act_high = 1;
    slow = 1;
    acc(24'h010000, 0, 5'h01, 0, 16'hA55A, 24'h010000);
    slow = 0;
    acc(24'h206000, 1, 5'h01, 0, 16'h0000, 24'h200000);
  endtask : t_windows

  task automatic t_internal();
    acc(24'h200010, 0, 5'h00, 0, 16'h1234, 24'h000000);
  endtask : t_internal

  // A hang counts as a mismatch and goes straight to the report.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      conclude();
    end
  end

  initial begin
    repeat (20) @(posedge ref_clk);
    #1 t_reset();
    resetn = 1;
    repeat (2) @(posedge ref_clk);
    #1 t_refuse();
    t_windows();
    t_internal();
    conclude();
  end
endmodule : testbench
`default_nettype wire
